/* File: shared/lbrg_pkg.sv */
// constants and types for the local bus request/grant block
`default_nettype none
package lbrg_pkg;
    typedef enum logic [4:0]
    {
        LBRG_IDLE  = 5'h01,
        LBRG_PEND  = 5'h02,
        LBRG_GRANT = 5'h04,
        LBRG_HOLD  = 5'h08,
        LBRG_GAP   = 5'h10
    } lbrg_state_e;

    localparam logic [1:0] QCODE_NOP   = 2'h0;
    localparam logic [1:0] QCODE_FIRST = 2'h1;
    localparam logic [1:0] QCODE_EMPTY = 2'h2;
    localparam logic [1:0] QCODE_NEXT  = 2'h3;
    localparam int         LINE_COUNT  = 2;
    localparam int         LINE_PRIO   = 0;
    localparam logic       LINE_IDLE_LEVEL = 1'h1;
    localparam logic       FORMER_BE_LEVEL = 1'h1;
endpackage : lbrg_pkg
`default_nettype wire

/* File: shared/lbrg_line_if.sv */
// carrier between a request/grant line watcher and the arbiter
`default_nettype none
interface lbrg_line_if;
    logic line_in;
    logic driving;
    logic pulse;
    modport watch (input line_in, input driving, output pulse);
    modport arb   (output line_in, output driving, input pulse);
endinterface : lbrg_line_if
`default_nettype wire

/* File: rtl/lbrg_line.sv */
// falling-edge pulse watcher for one request/grant line
`default_nettype none
module lbrg_line
(
    input  wire logic  clk_sys,
    input  wire logic  resetn,
    lbrg_line_if.watch lif
);
    logic prev;
    logic next_prev;
    logic pulse_q;
    logic next_pulse;

    always_comb
    begin
        next_prev  = lif.line_in;
        // our own grant pulse must not read back as a request
        next_pulse = prev & ~lif.line_in & ~lif.driving;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            prev    <= lbrg_pkg::LINE_IDLE_LEVEL;
            pulse_q <= 1'h0;
        end
        else
        begin
            prev    <= next_prev;
            pulse_q <= next_pulse;
        end
    end

    assign lif.pulse = pulse_q;
endmodule : lbrg_line
`default_nettype wire

/* File: rtl/lbrg_top.sv */
// maximum-mode local bus hand-over, lock and queue status logic
// Contract
// - line zero wins over line one when both request
// - accepted request gets one-clock grant pulse, bus floats, hold follows
// - in hold the bus interface drives none of the bus lines
// - third pulse ends hold; bus reclaimed next clock, final state follows
// - each hand-over is exactly three active-low pulses on one line
// - one idle clock separates an exchange from later bus activity
// - during a memory cycle release in final state if request by second state
// - no release after low byte, first interrupt ack, or while locked
// - idle bus at request: release next clock or start a memory cycle
// - a started cycle begins within three clocks, timing condition met
// - lock output low from lock prefix until next instruction completes
// - lock output floats during hold acknowledge
// - queue code shown in the clock after the queue operation
// - queue codes: 00 nop, 01 first byte, 10 emptied, 11 next byte
// - former byte-enable pin stays high in maximum mode
`default_nettype none
module lbrg_top
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       bus_handover_line_hi_in,
    output logic            bus_handover_line_hi_out,
    output logic            bus_handover_line_hi_oe,
    input  wire logic       bus_handover_line_lo_in,
    output logic            bus_handover_line_lo_out,
    output logic            bus_handover_line_lo_oe,
    input  wire logic       cyc_active,
    input  wire logic       cyc_early,
    input  wire logic       cyc_final,
    input  wire logic       cyc_start,
    input  wire logic       cyc_word_low,
    input  wire logic       cyc_inta_first,
    input  wire logic       lock_prefix,
    input  wire logic       instr_done,
    input  wire logic       queue_op_valid,
    input  wire logic [1:0] queue_op,
    output logic            core_hold,
    output logic            bus_float,
    output logic            lock_out_n,
    output logic            lock_oe,
    output logic            queue_code_bit_hi,
    output logic            queue_code_bit_lo,
    output logic            former_be_pin
);
    lbrg_line_if lif_hi ();
    lbrg_line_if lif_lo ();

    lbrg_line u_line_hi
    (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .lif     (lif_hi.watch)
    );

    lbrg_line u_line_lo
    (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .lif     (lif_lo.watch)
    );

    lbrg_pkg::lbrg_state_e state;
    lbrg_pkg::lbrg_state_e next_state;
    logic [1:0]            pend;
    logic [1:0]            next_pend;
    logic                  early_ok;
    logic                  next_early_ok;
    logic                  owner;
    logic                  next_owner;
    logic                  locked;
    logic                  next_locked;
    logic [1:0]            qcode;
    logic [1:0]            next_qcode;
    logic                  drive_hi;
    logic                  next_drive_hi;
    logic                  drive_lo;
    logic                  next_drive_lo;
    logic                  next_core_hold;
    logic                  next_bus_float;
    logic                  may_release;
    logic                  owner_pulse;

    assign lif_hi.line_in = bus_handover_line_hi_in;
    assign lif_lo.line_in = bus_handover_line_lo_in;
    assign lif_hi.driving = drive_hi;
    assign lif_lo.driving = drive_lo;
    assign owner_pulse    = owner ? lif_lo.pulse : lif_hi.pulse;

    always_comb
    begin
        may_release = ~cyc_word_low & ~cyc_inta_first & ~locked;
        next_state    = state;
        next_pend     = pend;
        next_early_ok = early_ok;
        next_owner    = owner;
        next_drive_hi = 1'h0;
        next_drive_lo = 1'h0;
        // requests are caught as low pulses on either line
        if (state == lbrg_pkg::LBRG_IDLE || state == lbrg_pkg::LBRG_PEND)
            next_pend = pend | {lif_lo.pulse, lif_hi.pulse};
        case (state)
            lbrg_pkg::LBRG_IDLE:
            begin
                if (lif_hi.pulse || lif_lo.pulse)
                begin
                    next_state = lbrg_pkg::LBRG_PEND;
                    // request counts as early up to the second state
                    next_early_ok = ~cyc_active | cyc_early;
                end
            end
            lbrg_pkg::LBRG_PEND:
            begin
                // a cycle started for a pending request is already early
                if (cyc_start)
                    next_early_ok = 1'h1;
                // idle bus without a new cycle releases now
                if ((!cyc_active && !cyc_start && may_release)
                    || (cyc_active && cyc_final && early_ok && may_release))
                begin
                    next_state = lbrg_pkg::LBRG_GRANT;
                    if (pend[lbrg_pkg::LINE_PRIO])
                    begin
                        next_owner    = 1'h0;
                        next_drive_hi = 1'h1;
                        next_pend[0]  = 1'h0;
                    end
                    else
                    begin
                        next_owner    = 1'h1;
                        next_drive_lo = 1'h1;
                        next_pend[1]  = 1'h0;
                    end
                end
                else if (cyc_active && cyc_final)
                    next_early_ok = 1'h1;
            end
            lbrg_pkg::LBRG_GRANT:
                next_state = lbrg_pkg::LBRG_HOLD;
            lbrg_pkg::LBRG_HOLD:
            begin
                // third pulse on the owner's line ends the hold
                if (owner_pulse)
                    next_state = lbrg_pkg::LBRG_GAP;
            end
            lbrg_pkg::LBRG_GAP:
                next_state = (pend != 2'h0) ? lbrg_pkg::LBRG_PEND : lbrg_pkg::LBRG_IDLE;
            default:
                next_state = lbrg_pkg::LBRG_IDLE;
        endcase
        // core stays held through the idle gap clock
        next_core_hold = (next_state != lbrg_pkg::LBRG_IDLE)
                         && !(next_state == lbrg_pkg::LBRG_PEND && state != lbrg_pkg::LBRG_GAP);
        // bus floats from grant through hold
        next_bus_float = (next_state == lbrg_pkg::LBRG_GRANT) || (next_state == lbrg_pkg::LBRG_HOLD);
        // lock from prefix until the following instruction completes
        next_locked = lock_prefix ? 1'h1 : (instr_done ? 1'h0 : locked);
        // code appears the clock after the operation
        next_qcode = queue_op_valid ? queue_op : lbrg_pkg::QCODE_NOP;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state     <= lbrg_pkg::LBRG_IDLE;
            pend      <= 2'h0;
            early_ok  <= 1'h0;
            owner     <= 1'h0;
            locked    <= 1'h0;
            qcode     <= lbrg_pkg::QCODE_NOP;
            drive_hi  <= 1'h0;
            drive_lo  <= 1'h0;
            core_hold <= 1'h0;
            bus_float <= 1'h0;
        end
        else
        begin
            state     <= next_state;
            pend      <= next_pend;
            early_ok  <= next_early_ok;
            owner     <= next_owner;
            locked    <= next_locked;
            qcode     <= next_qcode;
            drive_hi  <= next_drive_hi;
            drive_lo  <= next_drive_lo;
            core_hold <= next_core_hold;
            bus_float <= next_bus_float;
        end
    end

    // grant pulse is one clock low, on the requester's own line
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            bus_handover_line_hi_out <= lbrg_pkg::LINE_IDLE_LEVEL;
            bus_handover_line_hi_oe  <= 1'h0;
            bus_handover_line_lo_out <= lbrg_pkg::LINE_IDLE_LEVEL;
            bus_handover_line_lo_oe  <= 1'h0;
            lock_out_n               <= 1'h1;
            lock_oe                  <= 1'h1;
            queue_code_bit_hi        <= 1'h0;
            queue_code_bit_lo        <= 1'h0;
            former_be_pin            <= lbrg_pkg::FORMER_BE_LEVEL;
        end
        else
        begin
            bus_handover_line_hi_out <= ~next_drive_hi;
            bus_handover_line_hi_oe  <= next_drive_hi;
            bus_handover_line_lo_out <= ~next_drive_lo;
            bus_handover_line_lo_oe  <= next_drive_lo;
            // lock low keeps other system masters off
            lock_out_n <= ~next_locked;
            lock_oe <= ~next_bus_float;
            queue_code_bit_hi <= next_qcode[1];
            queue_code_bit_lo <= next_qcode[0];
            former_be_pin <= lbrg_pkg::FORMER_BE_LEVEL;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_grant_width: assert property (bus_handover_line_hi_oe |=> !bus_handover_line_hi_oe)
        else $error("grant pulse on line zero longer than one clock");
    a_grant_hold: assert property ((state == lbrg_pkg::LBRG_GRANT) |=> (state == lbrg_pkg::LBRG_HOLD) && bus_float)
        else $error("hold acknowledge not entered after grant");
    a_hold_float: assert property ((state == lbrg_pkg::LBRG_HOLD) |-> bus_float && !lock_oe)
        else $error("bus or lock driven in hold");
    a_hold_end: assert property ((state == lbrg_pkg::LBRG_HOLD) && owner_pulse |=> !bus_float ##1 !core_hold || (state != lbrg_pkg::LBRG_IDLE))
        else $error("bus not reclaimed after end pulse");
    a_gap_idle: assert property ((state == lbrg_pkg::LBRG_GAP) |-> core_hold && !bus_float)
        else $error("no idle clock after exchange");
    a_prio_zero: assert property ((state == lbrg_pkg::LBRG_PEND) && pend[0] && next_state == lbrg_pkg::LBRG_GRANT |=> bus_handover_line_hi_oe && !bus_handover_line_lo_oe)
        else $error("line one granted over line zero");
    a_no_release: assert property ((state == lbrg_pkg::LBRG_PEND) && (cyc_word_low || cyc_inta_first || locked) |=> state != lbrg_pkg::LBRG_GRANT)
        else $error("bus released while blocked");
    a_idle_release: assert property ((state == lbrg_pkg::LBRG_PEND) && !cyc_active && !cyc_start && !cyc_word_low && !cyc_inta_first && !locked |=> state == lbrg_pkg::LBRG_GRANT)
        else $error("idle bus not released next clock");
    a_lock_follow: assert property (lock_prefix |=> !lock_out_n until_with instr_done)
        else $error("lock released early");
    a_queue_delay: assert property (queue_op_valid |=> {queue_code_bit_hi, queue_code_bit_lo} == $past(queue_op))
        else $error("queue code not shown next clock");
    a_be_high: assert property (former_be_pin)
        else $error("former byte-enable pin not high");

    c_idle_grant: cover property ((state == lbrg_pkg::LBRG_PEND) && !cyc_active ##1 state == lbrg_pkg::LBRG_GRANT);
    c_cycle_grant: cover property ((state == lbrg_pkg::LBRG_PEND) && cyc_final ##1 state == lbrg_pkg::LBRG_GRANT);
    c_both_lines: cover property (pend == 2'h3);
    c_full_exchange: cover property ((state == lbrg_pkg::LBRG_HOLD) ##1 (state == lbrg_pkg::LBRG_GAP));
endmodule : lbrg_top
`default_nettype wire

/* File: tb/lbrg_master_model.sv */
// behavioural local bus master that asks for the bus on one request/grant line
`default_nettype none
module lbrg_master_model
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic       line_level,
    input  wire logic [3:0] hold_len,
    output logic            drive_low,
    output logic            granted,
    output logic            done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] st;
    logic [3:0] cnt;
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            st <= 3'h0;
            cnt <= 4'h0;
            drive_low <= 1'h0;
            granted <= 1'h0;
            done <= 1'h0;
        end
        else
        begin
            case (st)
                3'h0: if (start)
                begin
                    drive_low <= 1'h1;
                    done <= 1'h0;
                    st <= 3'h1;
                end
                3'h1:
                begin
                    drive_low <= 1'h0;
                    st <= 3'h2;
                end
                // line low after release is the grant pulse
                3'h2: if (!line_level)
                begin
                    granted <= 1'h1;
                    cnt <= hold_len;
                    st <= 3'h3;
                end
                // third pulse on the same line ends the hold
                3'h3: if (cnt == 4'h0)
                begin
                    drive_low <= 1'h1;
                    st <= 3'h4;
                end
                else
                    cnt <= cnt - 4'h1;
                3'h4:
                begin
                    drive_low <= 1'h0;
                    granted <= 1'h0;
                    done <= 1'h1;
                    st <= 3'h5;
                end
                // idle clock before any new request
                default: st <= 3'h0;
            endcase
        end
    end
endmodule : lbrg_master_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the request/grant, lock and queue status block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, resetn, start_hi, start_lo, drv_hi, drv_lo, done_hi, done_lo, line_hi, line_lo;
    logic hi_out, hi_oe, lo_out, lo_oe, c_act, c_early, c_final, c_start, c_wl, c_ia;
    logic lock_prefix, instr_done, q_valid, core_hold, bus_float, lock_out_n, lock_oe, q_hi, q_lo, be_pin;
    logic [1:0] q_op;
    int         error_cnt, tests_run, grant_cnt;
    // pull-up on both lines; any low driver wins
    assign line_hi = !(hi_oe && !hi_out) && !drv_hi;
    assign line_lo = !(lo_oe && !lo_out) && !drv_lo;
    lbrg_top lbrg_top_i (.clk_sys(clk_sys), .resetn(resetn), .bus_handover_line_hi_in(line_hi),
        .bus_handover_line_hi_out(hi_out), .bus_handover_line_hi_oe(hi_oe), .bus_handover_line_lo_in(line_lo),
        .bus_handover_line_lo_out(lo_out), .bus_handover_line_lo_oe(lo_oe), .cyc_active(c_act),
        .cyc_early(c_early), .cyc_final(c_final), .cyc_start(c_start), .cyc_word_low(c_wl),
        .cyc_inta_first(c_ia), .lock_prefix(lock_prefix), .instr_done(instr_done), .queue_op_valid(q_valid),
        .queue_op(q_op), .core_hold(core_hold), .bus_float(bus_float), .lock_out_n(lock_out_n),
        .lock_oe(lock_oe), .queue_code_bit_hi(q_hi), .queue_code_bit_lo(q_lo), .former_be_pin(be_pin));
    lbrg_master_model lbrg_master_model_i (.clk_sys(clk_sys), .resetn(resetn), .start(start_hi),
        .line_level(line_hi), .hold_len(4'h3), .drive_low(drv_hi), .granted(), .done(done_hi));
    lbrg_master_model lbrg_master_model_lo_i (.clk_sys(clk_sys), .resetn(resetn), .start(start_lo),
        .line_level(line_lo), .hold_len(4'h1), .drive_low(drv_lo), .granted(), .done(done_lo));
    initial
    begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    // grant pulses on line zero; tests compare against a snapshot
    always @(posedge clk_sys) grant_cnt <= grant_cnt + int'(hi_oe);
    task tick;
        @(posedge clk_sys);
        #1;
    endtask : tick
    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    function logic pick(input int k);
        case (k)
            0: return hi_oe;
            1: return bus_float;
            2: return lo_oe;
            default: return done_hi;
        endcase
    endfunction : pick
    // bounded wait; running out counts a mismatch and closes the run
    task wait_for(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(k) !== v && n < lim)
        begin
            tick;
            n++;
        end
        if (pick(k) !== v)
        begin
            chk(8'h00, 8'h01);
            wrap_up;
        end
    endtask : wait_for
    task do_reset;
        resetn <= 1'h0;
        repeat (10) tick;
        resetn <= 1'h1;
        chk({1'h0, hi_oe, lo_oe, bus_float, core_hold, lock_out_n, lock_oe, be_pin}, 8'h07);
        chk({6'h00, q_hi, q_lo}, 8'h00);
        $display("reset test done");
    endtask : do_reset
    task finish_hold(input logic lo);
        wait_for(1, 1'h0, 30);
        chk(8'(lo ? done_lo : done_hi), 8'h01);
        chk(8'(core_hold), 8'h01);
        tick;
        chk(8'(core_hold), 8'h00);
    endtask : finish_hold
    task test_idle;
        start_hi <= 1'h1;
        tick;
        start_hi <= 1'h0;
        wait_for(0, 1'h1, 6);
        chk(8'({hi_out, bus_float, lock_oe, core_hold}), 8'h05);
        tick;
        chk(8'({hi_oe, bus_float}), 8'h01);
        finish_hold(1'h0);
        $display("idle handover test done");
    endtask : test_idle
    // first to final state; cycle signals stay up so a next cycle can follow at once
    task mem_cycle(input logic wl, input logic ia);
        {c_start, c_act, c_early, c_final, c_wl, c_ia} <= {4'hE, wl, ia};
        tick;
        {c_start, start_hi} <= 2'h0;
        repeat (2) tick;
        {c_early, c_final} <= 2'h1;
        tick;
    endtask : mem_cycle
    task test_busy;
        int g0;
        g0 = grant_cnt;
        start_hi <= 1'h1;
        mem_cycle(1'h1, 1'h0);
        // no idle clock between cycles, else an idle-bus release is legal
        chk({7'(grant_cnt - g0), hi_oe}, 8'h00);
        mem_cycle(1'h0, 1'h1);
        chk({7'(grant_cnt - g0), hi_oe}, 8'h00);
        mem_cycle(1'h0, 1'h0);
        {c_act, c_final, c_wl, c_ia} <= 4'h0;
        wait_for(0, 1'h1, 4);
        finish_hold(1'h0);
        $display("busy bus test done");
    endtask : test_busy
    task test_lock;
        int g0;
        lock_prefix <= 1'h1;
        tick;
        lock_prefix <= 1'h0;
        tick;
        chk(8'(lock_out_n), 8'h00);
        g0 = grant_cnt;
        start_hi <= 1'h1;
        tick;
        start_hi <= 1'h0;
        repeat (8) tick;
        chk({6'(grant_cnt - g0), hi_oe, lock_out_n}, 8'h00);
        instr_done <= 1'h1;
        tick;
        instr_done <= 1'h0;
        wait_for(0, 1'h1, 6);
        chk(8'({lock_out_n, lock_oe}), 8'h02);
        finish_hold(1'h0);
        $display("lock test done");
    endtask : test_lock
    task test_queue;
        for (int i = 1; i < 4; i++)
        begin
            q_op <= 2'(i);
            q_valid <= 1'h1;
            tick;
            q_valid <= 1'h0;
            chk(8'({q_hi, q_lo}), 8'(i));
            tick;
            chk(8'({q_hi, q_lo}), 8'h00);
        end
        $display("queue status test done");
    endtask : test_queue
    task test_prio;
        {start_hi, start_lo} <= 2'h3;
        tick;
        {start_hi, start_lo} <= 2'h0;
        wait_for(0, 1'h1, 6);
        chk(8'(lo_oe), 8'h00);
        wait_for(2, 1'h1, 20);
        chk(8'({lo_out, bus_float, done_hi, core_hold}), 8'h07);
        finish_hold(1'h1);
        $display("priority test done");
    endtask : test_prio
    initial
    begin
        {resetn, start_hi, start_lo, c_act, c_early, c_final, c_start, c_wl, c_ia} = 9'h000;
        {lock_prefix, instr_done, q_valid, q_op} = 5'h00;
        error_cnt = 0;
        tests_run = 0;
        do_reset;
        test_idle;
        test_busy;
        test_lock;
        test_queue;
        test_prio;
        do_reset;
        test_idle;
        wrap_up;
    end
endmodule : tb
`default_nettype wire
